// File: logic/spu_consts.svh
`ifndef SPU_CONSTS_SVH
`define SPU_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------
`define SPU_OFS_CTRL 2'h0
`define SPU_OFS_DATA 2'h1
`define SPU_OFS_DIV 2'h2

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define SPU_BIT_DONE 7
`define SPU_BIT_MASTER 6
`define SPU_BIT_FAULT 5
`define SPU_BIT_SEL_HI 3
`define SPU_BIT_SEL_LO 2
`define SPU_BIT_ENABLE 0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SPU_CTRL_RST 8'h04
`define SPU_DIV_RST 8'h03
`define SPU_BYTE_BITS 4'h8

`endif

// File: logic/spu_pkg.sv
package spu_pkg;

  // Master transfer sequencer states
  typedef enum logic [0:0] {
    SPU_IDLE,
    SPU_SHIFT
  } spu_xfer_t;

  typedef logic [7:0] spu_byte_t;
  typedef logic [1:0] spu_sel_mode_t;

endpackage

// File: logic/spu_serial_port_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - Master drives data-out; slave only listens
// - Master listens on data-in; slave drives
// - Bytes shift most significant bit first
// - Master data-out shows shift register MSB
// - Data-in floats when disabled or unselected
// - 3-wire slave always drives shift MSB
// - Clock driven only as master
// - Unselected 4-wire slave ignores clock
// - Mode 00: 3-wire, slave always selected
// - Mode 01: select input, low selects
// - Multi-master select fall disables master
// - Mode 1x: select output equals low bit
// - Select pin mapped except in 3-wire
// - Byte end sets transfer-done flag
// - Fault clears master, enable; sets fault flag
// - Select fall resets 4-wire slave bit counter
`include "spu_consts.svh"

module spu_serial_port_unit
  import spu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sel_in,
  output logic sel_out,
  output logic sel_oe,
  output logic sel_pin_mapped
);

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  logic done_reg;
  logic master_reg;
  logic fault_reg;
  spu_sel_mode_t sel_mode_reg;
  logic enable_reg;
  spu_byte_t div_reg;
  spu_byte_t rx_buf_reg;
  spu_byte_t tx_buf_reg;
  logic tx_full_reg;
  spu_byte_t shift_reg;
  logic loaded_reg;
  logic [3:0] bit_cnt_reg;
  logic rx_bit_reg;
  spu_xfer_t xfer_reg;
  spu_byte_t div_cnt_reg;
  logic sck_gen_reg;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic sel_s1_reg, sel_s2_reg, sel_s3_reg;
  logic mosi_s1_reg, mosi_s2_reg;
  logic miso_s1_reg, miso_s2_reg;

  // Two flops per pin; third flop only for edge finding
  always_ff @(posedge mclk) begin
    if (rst) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sel_s3_reg <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else begin
      sck_s1_reg <= sck_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      sel_s1_reg <= sel_in;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      mosi_s1_reg <= mosi_in;
      mosi_s2_reg <= mosi_s1_reg;
      miso_s1_reg <= miso_in;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------------
  logic sck_rise, sck_fall, sel_fall;
  logic is_master, is_slave, slave_selected, mode_fault_hit;
  logic wr_ctrl, wr_data, wr_div;
  logic gen_rise, gen_fall, div_hit;
  logic slv_rise, slv_fall, byte_end, load_now;
  spu_byte_t shift_next;

  assign sck_rise = sck_s2_reg & ~sck_s3_reg;
  assign sck_fall = ~sck_s2_reg & sck_s3_reg;
  assign sel_fall = ~sel_s2_reg & sel_s3_reg;

  assign is_master = enable_reg & master_reg;
  assign is_slave = enable_reg & ~master_reg;
  // Mode 00 acts as permanently selected; 01 selects on a low level
  assign slave_selected = (sel_mode_reg == 2'b00) |
                          ((sel_mode_reg == 2'b01) & ~sel_s2_reg);

  // Another master pulled select low while we hold the bus
  assign mode_fault_hit = is_master & (sel_mode_reg == 2'b01) & sel_fall;

  assign wr_ctrl = reg_wr & (reg_addr == `SPU_OFS_CTRL);
  assign wr_data = reg_wr & (reg_addr == `SPU_OFS_DATA);
  assign wr_div = reg_wr & (reg_addr == `SPU_OFS_DIV);

  // Master clock edges, produced by the half-period divider
  assign div_hit = (xfer_reg == SPU_SHIFT) & (div_cnt_reg == div_reg);
  assign gen_rise = div_hit & ~sck_gen_reg;
  assign gen_fall = div_hit & sck_gen_reg;

  // Slave clock edges count only while selected
  assign slv_rise = is_slave & slave_selected & sck_rise;
  assign slv_fall = is_slave & slave_selected & sck_fall;

  // A byte closes on the falling edge after the eighth rising edge
  assign byte_end = (gen_fall | slv_fall) & (bit_cnt_reg == `SPU_BYTE_BITS);
  // Master reads data-in at its own fall: the pin round trip lags three clocks
  assign shift_next = {shift_reg[6:0], gen_fall ? miso_s2_reg : rx_bit_reg};

  // Move the transmit buffer into an empty shift register
  assign load_now = tx_full_reg & enable_reg & ~loaded_reg & (xfer_reg == SPU_IDLE);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------

  // Fault wins over a same-cycle software write of the enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      master_reg <= 1'(`SPU_CTRL_RST >> `SPU_BIT_MASTER);
      enable_reg <= 1'b0;
      sel_mode_reg <= 2'(`SPU_CTRL_RST >> `SPU_BIT_SEL_LO);
    end else if (mode_fault_hit) begin
      master_reg <= 1'b0;
      enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      master_reg <= reg_wdata[`SPU_BIT_MASTER];
      enable_reg <= reg_wdata[`SPU_BIT_ENABLE];
      sel_mode_reg <= reg_wdata[`SPU_BIT_SEL_HI:`SPU_BIT_SEL_LO];
    end
  end

  // Sticky flags: a set in the clearing cycle survives
  always_ff @(posedge mclk) begin
    if (rst) begin
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      if (byte_end) begin
        done_reg <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[`SPU_BIT_DONE]) begin
        done_reg <= 1'b0;
      end
      if (mode_fault_hit) begin
        fault_reg <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[`SPU_BIT_FAULT]) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // Master clock half-period, in system clocks minus one
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_reg <= `SPU_DIV_RST;
    end else if (wr_div) begin
      div_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------------

  // A write while the buffer is still full is dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_buf_reg <= 8'h00;
      tx_full_reg <= 1'b0;
    end else if (!enable_reg) begin
      tx_full_reg <= 1'b0;
    end else if (wr_data && !tx_full_reg) begin
      tx_buf_reg <= reg_wdata;
      tx_full_reg <= 1'b1;
    end else if (load_now || (byte_end && tx_full_reg)) begin
      tx_full_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------------

  // Starts when a master byte is loaded; fault or disable aborts
  always_ff @(posedge mclk) begin
    if (rst) begin
      xfer_reg <= SPU_IDLE;
      div_cnt_reg <= 8'h00;
      sck_gen_reg <= 1'b0;
    end else if (!is_master || mode_fault_hit) begin
      xfer_reg <= SPU_IDLE;
      div_cnt_reg <= 8'h00;
      sck_gen_reg <= 1'b0;
    end else begin
      unique case (xfer_reg)
        SPU_IDLE: begin
          div_cnt_reg <= 8'h00;
          sck_gen_reg <= 1'b0;
          if (loaded_reg) begin
            xfer_reg <= SPU_SHIFT;
          end
        end
        SPU_SHIFT: begin
          if (div_hit) begin
            div_cnt_reg <= 8'h00;
            sck_gen_reg <= ~sck_gen_reg;
          end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
          end
          // Back-to-back bytes go straight on if the next is waiting
          if (byte_end && !tx_full_reg) begin
            xfer_reg <= SPU_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------------

  // Slave samples on rising clock; both roles shift on falling, MSB first
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_reg <= 8'h00;
      loaded_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      rx_bit_reg <= 1'b0;
    end else if (!enable_reg || mode_fault_hit) begin
      // Disabling is the only way to resync a 3-wire slave
      loaded_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end else begin
      if (is_slave && sel_mode_reg == 2'b01 && sel_fall) begin
        bit_cnt_reg <= 4'h0;
      end else if (gen_rise || slv_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (byte_end) begin
        bit_cnt_reg <= 4'h0;
      end
      if (slv_rise) begin
        rx_bit_reg <= mosi_s2_reg;
      end
      if (load_now) begin
        shift_reg <= tx_buf_reg;
        loaded_reg <= 1'b1;
      end else if (byte_end) begin
        // Next byte follows the last clock edge if one is waiting
        shift_reg <= tx_full_reg ? tx_buf_reg : shift_next;
        loaded_reg <= tx_full_reg;
      end else if (gen_fall || slv_fall) begin
        shift_reg <= shift_next;
      end
    end
  end

  // Received byte lands in the receive buffer at byte end
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_buf_reg <= 8'h00;
    end else if (byte_end) begin
      rx_buf_reg <= shift_next;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SPU_OFS_CTRL: reg_rdata <= {done_reg, master_reg, fault_reg, 1'b0,
                                     sel_mode_reg, 1'b0, enable_reg};
        `SPU_OFS_DATA: reg_rdata <= rx_buf_reg;
        `SPU_OFS_DIV: reg_rdata <= div_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------

  // Data and clock line direction follows the role
  always_ff @(posedge mclk) begin
    if (rst) begin
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      mosi_out <= shift_reg[7];
      mosi_oe <= is_master & ~mode_fault_hit;
      sck_out <= sck_gen_reg;
      sck_oe <= is_master & ~mode_fault_hit;
    end
  end

  // Slave output floats unless enabled and selected
  always_ff @(posedge mclk) begin
    if (rst) begin
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_out <= shift_reg[7];
      miso_oe <= is_slave & slave_selected;
    end
  end

  // Select pin: output only in 1x, unmapped in 3-wire
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_out <= 1'b1;
      sel_oe <= 1'b0;
      sel_pin_mapped <= 1'b1;
    end else begin
      sel_out <= sel_mode_reg[0];
      sel_oe <= sel_mode_reg[1];
      sel_pin_mapped <= (sel_mode_reg != 2'b00);
    end
  end

endmodule

// File: dv/spu_pin_monitor.sv
`timescale 1ns/1ps
`include "spu_consts.svh"
// --------
// Pin checks
// --------
module spu_pin_monitor
  import spu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic miso_out,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sel_in,
  input wire logic sel_out,
  input wire logic sel_oe,
  input wire logic sel_pin_mapped
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Unselected select-input slave, no register traffic
  sequence s_unsel;
    !mosi_oe && sel_pin_mapped && !sel_oe && sel_in && !reg_wr;
  endsequence
  // Mode write, one quiet cycle, then pins follow
  property p_sel_follow;
    logic [1:0] m;
    (reg_wr && reg_addr == `SPU_OFS_CTRL, m = reg_wdata[3:2]) ##1 !reg_wr |=>
      sel_oe == m[1] && sel_out == m[0] && sel_pin_mapped == (m != 2'h0);
  endproperty
  a_data_dirs: assert property (mosi_oe == sck_oe && !(mosi_oe && miso_oe))
    else $error("data pin directions clash");
  a_clock_owner: assert property (!sck_oe && !$past(sck_oe) |-> $stable(sck_out))
    else $error("clock moved while not master");
  a_miso_float: assert property (s_unsel [*6] |-> !miso_oe)
    else $error("data-in driven while unselected");
  a_unsel_ignore: assert property (s_unsel [*8] |-> $stable(miso_out))
    else $error("unselected slave shifted");
  a_sel_follows: assert property (p_sel_follow)
    else $error("select pin does not follow mode");
  a_fault_drop: assert property (mosi_oe && sel_pin_mapped && !sel_oe && $fell(sel_in)
    |-> ##[1:6] (!mosi_oe && !sck_oe)) else $error("master kept after select fall");
  a_three_wire: assert property (!sel_pin_mapped |-> !sel_oe && !sel_out)
    else $error("select used in three-wire mode");
  a_sel_mapped: assert property (sel_oe |-> sel_pin_mapped)
    else $error("select output not mapped");
endmodule

bind spu_serial_port_unit spu_pin_monitor mon_u (
  .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .mosi_oe, .miso_oe,
  .miso_out, .sck_out, .sck_oe, .sel_in, .sel_out, .sel_oe, .sel_pin_mapped
);

// File: dv/spu_far_side.sv
`timescale 1ns/1ps
// --------
// Far device: slave to our master, master to our slave
// --------
module spu_far_side
  import spu_pkg::*;
(
  input wire logic mclk,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sel_out,
  input wire logic sel_oe,
  output logic mosi_in,
  output logic miso_in,
  output logic sck_in,
  output logic sel_in
);
  spu_byte_t s_tx, s_rx;
  logic sck_m, mosi_m, sel_m;
  // Pin levels: the enabled party drives; sole far slave on the bus
  assign sck_in = sck_oe ? sck_out : sck_m;
  assign mosi_in = mosi_oe ? mosi_out : mosi_m;
  assign miso_in = miso_oe ? miso_out : s_tx[7];
  assign sel_in = sel_oe ? sel_out : sel_m;
  initial begin
    sck_m = 1'b0;
    mosi_m = 1'b0;
    sel_m = 1'b1;
    s_tx = 8'h00;
  end
  // Slave side: sample on rise, shift on fall, filler bits toggle
  always @(posedge sck_out) if (sck_oe) s_rx <= {s_rx[6:0], mosi_out};
  always @(negedge sck_out) if (sck_oe) s_tx <= {s_tx[6:0], ~s_tx[7]};
  // Master side: clock still outside frames, select leads by 3 clocks
  // Pin moves stay 2 ns past a system edge so no sampler races them
  task automatic xfer(spu_byte_t tx, int n, logic s, output spu_byte_t rx);
    int i;
    @(posedge mclk);
    #2 sel_m = s;
    repeat (3) @(posedge mclk);
    #2;
    for (i = 7; i > 7 - n; i--) begin
      mosi_m = tx[i];
      #40 sck_m = 1'b1;
      rx = {rx[6:0], miso_in};
      #40 sck_m = 1'b0;
    end
    #40 sel_m = 1'b1;
    mosi_m = ~mosi_m;
  endtask
endmodule

// File: dv/test_spu_serial_port_unit.sv
`timescale 1ns/1ps
// --------
// Bench
// --------
module test_spu_serial_port_unit;
  import spu_pkg::*;
  logic mclk, rst, reg_wr, reg_rd;
  logic [1:0] reg_addr;
  spu_byte_t reg_wdata, reg_rdata, t, v, r;
  logic mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
  logic sck_in, sck_out, sck_oe, sel_in, sel_out, sel_oe, sel_pin_mapped;
  int n_fail, compares, i;
  spu_serial_port_unit dut_u (.*);
  spu_far_side far_u (.*);
  // Expected control value
  function automatic spu_byte_t ctl(logic ms, logic [1:0] m, logic en);
    return {1'b0, ms, 2'b00, m, 1'b0, en};
  endfunction
  task automatic chk(string s, spu_byte_t e, spu_byte_t g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // Register port cycles
  task automatic w(logic [1:0] a, spu_byte_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(logic [1:0] a, output spu_byte_t d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chkr(string s, logic [1:0] a, spu_byte_t e);
    spu_byte_t d;
    rdr(a, d);
    chk(s, e, d);
  endtask
  task automatic pause(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Poll done under a bound, then clear it
  task automatic wait_done();
    spu_byte_t d;
    int k;
    d = 8'h00;
    for (k = 0; k < 200 && d[7] !== 1'b1; k++) rdr(2'h0, d);
    chk("done", 1, d[7]);
    w(2'h0, d & 8'h7f);
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Watchdog well past the expected run
  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    results();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    void'($urandom(65615));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    chkr("ctrl", 2'h0, 8'h04);
    chkr("div", 2'h2, 8'h03);
    chkr("unmapped", 2'h3, 8'h00);
    chk("miso_oe", 0, miso_oe);
    $display("test reset done");
    // Every select mode
    for (i = 0; i < 4; i++) begin
      w(2'h0, ctl(0, i[1:0], 0));
      pause(3);
      chk("sel_oe", i[1], sel_oe);
      chk("mapped", i != 0, sel_pin_mapped);
      if (i[1]) chk("sel_out", i[0], sel_out);
    end
    $display("test modes done");
    // Master with select output low, corner then random bytes
    w(2'h0, ctl(1, 2, 1));
    for (i = 0; i < 6; i++) begin
      t = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($urandom);
      far_u.s_tx = 8'($urandom);
      v = far_u.s_tx;
      w(2'h2, 8'($urandom_range(3, 1)));
      w(2'h1, t);
      wait_done();
      chk("far rx", t, far_u.s_rx);
      chkr("master rx", 2'h1, v);
      chk("mosi_oe", 1, mosi_oe);
      chk("sck_oe", 1, sck_oe);
      chk("miso_oe", 0, miso_oe);
    end
    $display("test master done");
    // Four-wire slave, last byte after a cut-short frame
    w(2'h0, ctl(0, 1, 1));
    pause(8);
    chk("miso_oe", 0, miso_oe);
    for (i = 0; i < 5; i++) begin
      t = 8'($urandom);
      v = 8'($urandom);
      if (i == 4) far_u.xfer(8'h00, 3, 1'b0, r);
      if (i < 4) w(2'h1, t);
      far_u.xfer(v, 8, 1'b0, r);
      if (i < 4) chk("slave tx", t, r);
      wait_done();
      chkr("slave rx", 2'h1, v);
    end
    far_u.xfer(8'hff, 8, 1'b1, r);
    chkr("ignored", 2'h0, ctl(0, 1, 1));
    $display("test slave done");
    // Three-wire slave answers with select high
    w(2'h0, ctl(0, 0, 1));
    pause(4);
    chk("miso_oe", 1, miso_oe);
    t = 8'($urandom);
    v = 8'($urandom);
    w(2'h1, t);
    far_u.xfer(v, 8, 1'b1, r);
    chk("3w tx", t, r);
    wait_done();
    chkr("3w rx", 2'h1, v);
    $display("test three-wire done");
    // Select falls under a multi-master
    w(2'h0, ctl(1, 1, 1));
    pause(4);
    far_u.sel_m = 1'b0;
    pause(8);
    chk("mosi_oe", 0, mosi_oe);
    chkr("fault", 2'h0, ctl(0, 1, 0) | 8'h20);
    far_u.sel_m = 1'b1;
    w(2'h0, ctl(0, 1, 0));
    pause(3);
    chk("miso_oe", 0, miso_oe);
    $display("test fault done");
    results();
  end
endmodule
